// file: slave_port_defines.svh
`ifndef SLAVE_PORT_DEFINES_SVH
`define SLAVE_PORT_DEFINES_SVH

// Bus clock period in ns
`define BUS_CLK_PERIOD_NS 10
// Acknowledge delay after sampling edge, in bus clocks
`define ACK_DELAY_IDLE 1
`define ACK_DELAY_MASTER 5
// Least bus clocks from slave ack low to size ack low on a write
`define WRITE_SIZE_ACK_GAP 2
// Size ack driven high before release, in bus clocks (half rounded up)
`define SIZE_ACK_HIGH_CYCLES 1
// Widths
`define DATA_WIDTH 16
`define ADDR_WIDTH 6
`define DELAY_CNT_WIDTH 8

`endif

// file: slave_port_pkg.sv
package slave_port_pkg;
  `include "slave_port_defines.svh"

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_ACK,
    ST_ACKED,
    ST_SIZE_ACK,
    ST_SIZE_HIGH
  } access_state_e;

  typedef logic [`DATA_WIDTH-1:0] data_t;
  typedef logic [`ADDR_WIDTH-1:0] addr_t;
  typedef logic [`DELAY_CNT_WIDTH-1:0] count_t;
endpackage : slave_port_pkg

// file: access_sync_if.sv
`timescale 1ns/100ps
interface access_sync_if;
  logic selectRaw;
  logic selectSync;
  modport src (output selectRaw, input selectSync);
  modport sync (input selectRaw, output selectSync);
endinterface : access_sync_if

// file: select_synchronizer.sv
`timescale 1ns/100ps
module select_synchronizer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Select path
  access_sync_if.sync syncPort
);
  import slave_port_pkg::*;

  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_s;

  sync_s state_ff;
  sync_s nxt_state;

  // ----------------------------------------
  // Two-stage capture
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    // R1: two flip-flop sync
    nxt_state.stage1 = syncPort.selectRaw;
    nxt_state.stage2 = state_ff.stage1;
    if (!reset_n) begin
      nxt_state = '{stage1: 1'b1, stage2: 1'b1};
    end
  end

  always_ff @(posedge sys_clk) begin
    state_ff <= nxt_state;
  end

  assign syncPort.selectSync = state_ff.stage2;
endmodule : select_synchronizer

// file: slave_register_access_port.sv
// What this block does (R1-R7, R11, R12) and what the host must do (R8-R10)
// R1: Chip select passes a two-flop synchroniser.
// R2: Ack 1 clock idle, 5 when master.
// R3: Each master wait state adds one clock.
// R4: Memory request or select raises ack.
// R5: Write size ack at least 2 after ack.
// R6: Size ack high one clock, then released.
// R7: Select release ends access like strobe.
// R8: Host lowers strobe no later than select.
// R9: Host raises strobe within 1 clock.
// R10: Host keeps select high at least 1 clock.
// R11: Select ack held only while strobe low.
// R12: Data bus driven only on selected reads.
`timescale 1ns/100ps
`include "slave_port_defines.svh"
module slave_register_access_port (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Host pins
  input wire logic chip_select_n,
  input wire logic slave_addr_strobe_n,
  input wire logic slave_read_not_write,
  input wire logic shared_mem_request_n,
  input wire slave_port_pkg::addr_t reg_addr,
  input wire slave_port_pkg::data_t reg_data_in,
  output logic slave_access_ack_n,
  output logic size_ack_n,
  output logic size_ack_oe,
  output slave_port_pkg::data_t reg_data_out,
  output logic reg_data_oe,
  // Device core
  input wire logic bus_master_active,
  input wire logic master_wait_state,
  input wire slave_port_pkg::data_t core_read_data,
  output slave_port_pkg::addr_t core_addr,
  output slave_port_pkg::data_t core_write_data,
  output logic core_write_strobe,
  output logic core_read_strobe
);
  import slave_port_pkg::*;

  typedef struct packed {
    access_state_e state;
    count_t delay;
    logic [1:0] gap;
    logic isRead;
    logic strobeS1;
    logic strobeS2;
    logic memReqS1;
    logic memReqS2;
    logic rwS1;
    logic rwS2;
    addr_t addrS1;
    addr_t addrS2;
    data_t dataS1;
    data_t dataS2;
    logic ackN;
    logic sizeAckN;
    logic sizeAckOe;
    logic dataOe;
    data_t dataOut;
    addr_t addr;
    data_t wrData;
    logic wrStrobe;
    logic rdStrobe;
  } port_s;

  port_s st_ff;
  port_s nxt_st;
  logic selSync;
  logic selActive;
  logic strobeLow;
  logic memReq;

  access_sync_if syncBus ();
  assign syncBus.selectRaw = chip_select_n;

  // ----------------------------------------
  // Select synchroniser
  // ----------------------------------------
  // R1: select sampled on sys_clk through two flip-flops
  select_synchronizer uSync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .syncPort(syncBus)
  );
  assign selSync = syncBus.selectSync;

  function automatic count_t ackDelay(input logic master);
    ackDelay = master ? count_t'(`ACK_DELAY_MASTER) : count_t'(`ACK_DELAY_IDLE);
  endfunction : ackDelay

  assign strobeLow = !st_ff.strobeS2;
  assign memReq = !st_ff.memReqS2;
  // R7: select release ends access too
  assign selActive = !selSync && strobeLow;

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.strobeS1 = slave_addr_strobe_n;
    nxt_st.strobeS2 = st_ff.strobeS1;
    nxt_st.memReqS1 = shared_mem_request_n;
    nxt_st.memReqS2 = st_ff.memReqS1;
    nxt_st.rwS1 = slave_read_not_write;
    nxt_st.rwS2 = st_ff.rwS1;
    // Words stand still while strobe is low, so a plain copy is safe
    nxt_st.addrS1 = reg_addr;
    nxt_st.addrS2 = st_ff.addrS1;
    nxt_st.dataS1 = reg_data_in;
    nxt_st.dataS2 = st_ff.dataS1;
    nxt_st.wrStrobe = 1'b0;
    nxt_st.rdStrobe = 1'b0;
    case (st_ff.state)
      ST_IDLE: begin
        nxt_st.sizeAckOe = 1'b0;
        nxt_st.sizeAckN = 1'b1;
        nxt_st.dataOe = 1'b0;
        // R4: memory request acks directly
        nxt_st.ackN = !memReq;
        if (selActive) begin
          // R2: delay chosen by mastership
          nxt_st.delay = ackDelay(bus_master_active) - count_t'(1);
          nxt_st.isRead = st_ff.rwS2;
          nxt_st.addr = st_ff.addrS2;
          nxt_st.state = ST_WAIT_ACK;
        end
      end
      ST_WAIT_ACK: begin
        if (!selActive) begin
          nxt_st.state = ST_IDLE;
        end else if (bus_master_active && master_wait_state) begin
          // R3: wait states stretch delay
          nxt_st.delay = st_ff.delay;
        end else if (st_ff.delay == count_t'(0)) begin
          // R4: select raises the ack
          nxt_st.ackN = 1'b0;
          nxt_st.gap = 2'(`WRITE_SIZE_ACK_GAP - 1);
          nxt_st.rdStrobe = st_ff.isRead;
          nxt_st.state = ST_ACKED;
        end else begin
          nxt_st.delay = st_ff.delay - count_t'(1);
        end
      end
      ST_ACKED: begin
        if (!selActive) begin
          // R11: ack follows strobe
          nxt_st.ackN = 1'b1;
          nxt_st.state = ST_IDLE;
        end else if (st_ff.gap != 2'h0) begin
          nxt_st.gap = st_ff.gap - 2'h1;
        end else begin
          // R5: size ack after the gap
          nxt_st.sizeAckN = 1'b0;
          nxt_st.sizeAckOe = 1'b1;
          if (st_ff.isRead) begin
            // R12: drive data on read only
            nxt_st.dataOe = 1'b1;
            nxt_st.dataOut = core_read_data;
          end else begin
            nxt_st.wrData = st_ff.dataS2;
            nxt_st.wrStrobe = 1'b1;
          end
          nxt_st.state = ST_SIZE_ACK;
        end
      end
      ST_SIZE_ACK: begin
        if (!selActive) begin
          // R6: drive high before release
          nxt_st.ackN = 1'b1;
          nxt_st.sizeAckN = 1'b1;
          nxt_st.dataOe = 1'b0;
          nxt_st.state = ST_SIZE_HIGH;
        end
      end
      ST_SIZE_HIGH: begin
        nxt_st.sizeAckOe = 1'b0;
        nxt_st.state = ST_IDLE;
      end
      default: begin
        nxt_st.state = ST_IDLE;
      end
    endcase
    if (!reset_n) begin
      nxt_st = '0;
      nxt_st.state = ST_IDLE;
      nxt_st.strobeS1 = 1'b1;
      nxt_st.strobeS2 = 1'b1;
      nxt_st.memReqS1 = 1'b1;
      nxt_st.memReqS2 = 1'b1;
      nxt_st.ackN = 1'b1;
      nxt_st.sizeAckN = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    st_ff <= nxt_st;
  end

  assign slave_access_ack_n = st_ff.ackN;
  assign size_ack_n = st_ff.sizeAckN;
  assign size_ack_oe = st_ff.sizeAckOe;
  assign reg_data_out = st_ff.dataOut;
  assign reg_data_oe = st_ff.dataOe;
  assign core_addr = st_ff.addr;
  assign core_write_data = st_ff.wrData;
  assign core_write_strobe = st_ff.wrStrobe;
  assign core_read_strobe = st_ff.rdStrobe;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_IDLE_ACK_DELAY: assert property (@(posedge sys_clk) disable iff (!reset_n) // R2
    (st_ff.state == ST_IDLE && selActive && !bus_master_active) ##1 selActive
      |=> !slave_access_ack_n)
    else $error("ack not one clock after idle select");
  AST_WRITE_GAP: assert property (@(posedge sys_clk) disable iff (!reset_n) // R5
    $fell(size_ack_n) |-> $past(!slave_access_ack_n, 2))
    else $error("size ack too soon after slave ack");
  AST_SIZE_HIGH_RELEASE: assert property (@(posedge sys_clk) disable iff (!reset_n) // R6
    $rose(size_ack_n) |-> size_ack_oe ##1 !size_ack_oe)
    else $error("size ack not driven high then released");
  AST_ACK_FOLLOWS_STROBE: assert property (@(posedge sys_clk) disable iff (!reset_n) // R11
    (st_ff.state inside {ST_ACKED, ST_SIZE_ACK} && !selActive && !memReq)
      |=> slave_access_ack_n)
    else $error("ack held after strobe or select release");
  AST_DATA_ONLY_READ: assert property (@(posedge sys_clk) disable iff (!reset_n) // R12
    reg_data_oe |-> (st_ff.isRead && st_ff.state == ST_SIZE_ACK))
    else $error("data driven outside a read");
  AST_MEM_REQ_ACK: assert property (@(posedge sys_clk) disable iff (!reset_n) // R4
    (st_ff.state == ST_IDLE && memReq) |=> !slave_access_ack_n)
    else $error("memory request not acknowledged");
  AST_MASTER_DELAY: assert property (@(posedge sys_clk) disable iff (!reset_n) // R3
    (st_ff.state == ST_WAIT_ACK && bus_master_active && master_wait_state && selActive)
      |=> slave_access_ack_n)
    else $error("ack during master wait state");
  AST_SELECT_END: assert property (@(posedge sys_clk) disable iff (!reset_n) // R7
    (st_ff.state == ST_SIZE_ACK && !selActive) |=> (size_ack_n && !reg_data_oe))
    else $error("access not ended on select release");
  COV_READ: cover property (@(posedge sys_clk) $rose(reg_data_oe));
  COV_WRITE: cover property (@(posedge sys_clk) core_write_strobe);
  COV_MASTER: cover property (@(posedge sys_clk)
    st_ff.state == ST_WAIT_ACK && bus_master_active);
endmodule : slave_register_access_port

// file: host_bus_model.sv
`timescale 1ns/100ps
module host_bus_model (
  // Clock
  input wire logic sys_clk,
  // Host pins
  output logic chip_select_n,
  output logic slave_addr_strobe_n,
  output logic slave_read_not_write,
  output slave_port_pkg::addr_t reg_addr,
  output slave_port_pkg::data_t reg_data_in,
  input wire logic slave_access_ack_n,
  input wire logic size_ack_n,
  input wire logic size_ack_oe
);
  import slave_port_pkg::*;
  int ackLat, sizeGap, sizeHigh, relAt;
  logic ackBack;
  initial begin
    chip_select_n = 1'b1;
    slave_addr_strobe_n = 1'b1;
    slave_read_not_write = 1'b1;
    reg_addr = '0;
    reg_data_in = '0;
  end
  // Called just after a falling edge
  task automatic access(input logic rd, input addr_t a, input data_t d, input logic selFirst);
    int n;
    chip_select_n <= 1'b0;
    slave_addr_strobe_n <= 1'b0;
    slave_read_not_write <= rd;
    reg_addr <= a;
    reg_data_in <= rd ? ~reg_data_in : d;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (slave_access_ack_n !== 1'b0 && n < 40);
    ackLat = n;
    n = 0;
    while (size_ack_n !== 1'b0 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    sizeGap = n;
    @(negedge sys_clk);
    chip_select_n <= 1'b1;
    // strobe up to one clock late
    if (!selFirst) slave_addr_strobe_n <= 1'b1;
    @(negedge sys_clk);
    slave_addr_strobe_n <= 1'b1;
    // Released bus must not keep the old word
    reg_data_in <= ~reg_data_in;
    sizeHigh = 0;
    relAt = 0;
    n = 0;
    repeat (4) begin
      @(negedge sys_clk);
      n++;
      if (size_ack_oe === 1'b1 && size_ack_n === 1'b1) begin
        sizeHigh++;
        relAt = n;
      end
    end
    ackBack = slave_access_ack_n;
    repeat (3) @(negedge sys_clk);
  endtask : access
endmodule : host_bus_model

// file: test_slave_register_access_port.sv
`timescale 1ns/100ps
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin failCount++; \
  $display("FAIL t=%0t got %h exp %h", $time, a, e); end end
module test_slave_register_access_port;
  import slave_port_pkg::*;
  logic sys_clk, reset_n, chip_select_n, slave_addr_strobe_n, slave_read_not_write;
  logic shared_mem_request_n, bus_master_active, master_wait_state, slave_access_ack_n;
  logic size_ack_n, size_ack_oe, reg_data_oe, core_write_strobe, core_read_strobe, taken;
  addr_t reg_addr, core_addr;
  data_t reg_data_in, reg_data_out, core_read_data, core_write_data;
  int failCount, numChecks, cycles, rdPulses;
  integer seed = 26640;
  logic [21:0] expQ[$];
  logic [21:0] got;
  logic [21:0] expV;
  slave_register_access_port u_slave_register_access_port (.sys_clk, .reset_n,
    .chip_select_n, .slave_addr_strobe_n, .slave_read_not_write, .shared_mem_request_n,
    .reg_addr, .reg_data_in, .slave_access_ack_n, .size_ack_n, .size_ack_oe,
    .reg_data_out, .reg_data_oe, .bus_master_active, .master_wait_state,
    .core_read_data, .core_addr, .core_write_data, .core_write_strobe, .core_read_strobe);
  host_bus_model u_host_bus_model (.sys_clk, .chip_select_n, .slave_addr_strobe_n,
    .slave_read_not_write, .reg_addr, .reg_data_in, .slave_access_ack_n, .size_ack_n,
    .size_ack_oe);
  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    shared_mem_request_n = 1'b1;
    bus_master_active = 1'b0;
    master_wait_state = 1'b0;
    core_read_data = '0;
    taken = 1'b0;
  end
  always #5 sys_clk = ~sys_clk;
  task close_out;
    $display("Checks %0d, mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  // ------------------------------
  // Result watcher
  // ------------------------------
  always @(negedge sys_clk) begin
    cycles++;
    if (cycles > 2000) begin
      failCount++;
      close_out();
    end else begin
      got = {core_addr, core_write_strobe ? core_write_data : reg_data_out};
      if (core_read_strobe === 1'b1) rdPulses++;
      if (core_write_strobe === 1'b1 ||
          (reg_data_oe === 1'b1 && size_ack_n === 1'b0 && !taken)) begin
        `CHK(expQ.size() > 0, 1'b1)
        if (expQ.size() > 0) begin
          expV = expQ.pop_front();
          `CHK(got, expV)
        end
        taken = 1'b1;
      end
      if (size_ack_n !== 1'b0) taken = 1'b0;
    end
  end
  task automatic run(input logic rd, input logic selFirst, input logic mst, input int waits,
                     input int expLat);
    addr_t a;
    data_t d;
    int rd0;
    a = addr_t'($random(seed));
    rd0 = rdPulses;
    d = data_t'($random(seed));
    if (rd) core_read_data = d;
    expQ.push_back({a, d});
    bus_master_active = mst;
    fork
      u_host_bus_model.access(rd, a, d, selFirst);
      if (waits > 0) begin
        repeat (3) @(negedge sys_clk);
        master_wait_state = 1'b1;
        repeat (waits) @(negedge sys_clk);
        master_wait_state = 1'b0;
      end
    join
    bus_master_active = 1'b0;
    `CHK(u_host_bus_model.ackLat, expLat)
    if (!rd) `CHK(u_host_bus_model.sizeGap >= 2, 1'b1)
    `CHK(u_host_bus_model.sizeHigh, 1)
    `CHK(u_host_bus_model.relAt, 2)
    `CHK(rdPulses - rd0, int'(rd))
    `CHK(u_host_bus_model.ackBack, 1'b1)
    `CHK(reg_data_oe, 1'b0)
  endtask : run
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    for (int i = 0; i < 8; i++) run(i[0], 1'b0, 1'b0, 0, 4);
    run(1'b1, 1'b1, 1'b0, 0, 4);
    run(1'b0, 1'b1, 1'b0, 0, 4);
    run(1'b1, 1'b0, 1'b1, 0, 8);
    run(1'b0, 1'b0, 1'b1, 2, 10);
    shared_mem_request_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    `CHK(slave_access_ack_n, 1'b0)
    shared_mem_request_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    `CHK(slave_access_ack_n, 1'b1)
    reset_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK(size_ack_oe, 1'b0)
    reset_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    run(1'b0, 1'b0, 1'b0, 0, 4);
    `CHK(expQ.size(), 0)
    close_out();
  end
endmodule : test_slave_register_access_port
